// *** sdram_pkg.sv ***
// Shared constants and types for the synchronous DRAM command and bank block
package sdram_pkg;

   // Register byte offsets on the Avalon-MM slave
   localparam logic [4:0] REG_CONFIG = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_ERROR = 5'h08;
   localparam logic [4:0] REG_ROW0 = 5'h10;

   // CONFIG field positions
   localparam int unsigned CFG_CAS_LSB = 0;
   localparam int unsigned CFG_BL_LSB = 2;
   // STATUS field positions
   localparam int unsigned ST_MODE_LSB = 4;
   localparam int unsigned ST_BURST_BIT = 6;
   // ERROR field position
   localparam int unsigned ERR_ILLEGAL_BIT = 0;

   // Reset values
   localparam logic [1:0] CAS_RESET = 2'h2;
   localparam logic [2:0] BL_RESET = 3'h3;
   localparam logic WAIT_RESET = 1'b1;

   // Column-strobe latencies that are supported
   localparam logic [1:0] CAS_TWO = 2'h2;

   // Burst length codes
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;

   // Address bit that selects auto precharge or precharge of every bank
   localparam int unsigned AUTOPRECHARGE_BIT = 10;

   typedef enum logic [3:0] {
      CMD_DESELECT = 4'h0,
      CMD_NOP = 4'h1,
      CMD_ACTIVATE = 4'h2,
      CMD_PRECHARGE = 4'h3,
      CMD_WRITE = 4'h4,
      CMD_READ = 4'h5,
      CMD_MODE_SET = 4'h6,
      CMD_REFRESH = 4'h7,
      CMD_BURST_STOP = 4'h8
   } cmd_t;

   typedef enum logic [1:0] {
      PM_NORMAL = 2'h0,
      PM_SUSPEND = 2'h1,
      PM_POWER_DOWN = 2'h2,
      PM_SELF_REFRESH = 2'h3
   } power_mode_t;

endpackage : sdram_pkg

// *** sdram_cmd_if.sv ***
// Decoded command carrier between the decoder and the bank logic
`timescale 1ns/100ps
interface sdram_cmd_if;
   sdram_pkg::cmd_t cmd;
   logic live;
   logic cke_fall;
   logic idle_cmd;

   modport dec (output cmd, output live, output cke_fall, output idle_cmd);
   modport use_side (input cmd, input live, input cke_fall, input idle_cmd);
endinterface : sdram_cmd_if

// *** sdram_cmd_decode.sv ***
// Command decoder for the sampled strobes and clock-enable history
`timescale 1ns/100ps
module sdram_cmd_decode (
   // Sampled command strobes
   input logic i_cs_n,
   input logic i_ras_n,
   input logic i_cas_n,
   input logic i_we_n,
   // Clock enable, earlier and current sample
   input logic i_clk_gate_prev,
   input logic i_clk_gate,
   // Decoded command
   sdram_cmd_if.dec cmd_port
);

   always_comb begin
      if (i_cs_n) begin
         cmd_port.cmd = sdram_pkg::CMD_DESELECT; // [RL18]
      end else begin
         unique case ({i_ras_n, i_cas_n, i_we_n})
            3'h3: cmd_port.cmd = sdram_pkg::CMD_ACTIVATE; // [RL18]
            3'h2: cmd_port.cmd = sdram_pkg::CMD_PRECHARGE;
            3'h4: cmd_port.cmd = sdram_pkg::CMD_WRITE;
            3'h5: cmd_port.cmd = sdram_pkg::CMD_READ;
            3'h0: cmd_port.cmd = sdram_pkg::CMD_MODE_SET;
            3'h1: cmd_port.cmd = sdram_pkg::CMD_REFRESH;
            3'h7: cmd_port.cmd = sdram_pkg::CMD_NOP;
            3'h6: cmd_port.cmd = sdram_pkg::CMD_BURST_STOP;
         endcase
      end
   end

   // Ordinary commands need the earlier clock-enable sample high
   assign cmd_port.live = i_clk_gate_prev; // [RL10]
   assign cmd_port.cke_fall = i_clk_gate_prev && !i_clk_gate; // [RL10]
   assign cmd_port.idle_cmd = i_cs_n || ({i_ras_n, i_cas_n, i_we_n} == 3'h7);

endmodule : sdram_cmd_decode

// *** sdram_command_bank_activate.sv ***
// Four-bank synchronous DRAM command, bank activation and power-mode logic
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
// Functional notes
// [RL1] Sample all command inputs on rising edge
// [RL2] Activate opens selected bank
// [RL3] Activate latches twelve-bit row address
// [RL4] Controller waits row-to-column delay before access
// [RL5] Controller precharges before activating another row
// [RL6] Controller spaces same-bank activates by cycle time
// [RL7] Controller spaces activates across banks
// [RL8] Address bit ten selects auto precharge
// [RL9] Reads and writes legal only to active bank
// [RL10] Commands need earlier clock enable high
// [RL11] Clock enable fall with active bank suspends; code enters power down instead when the command is idle and no burst runs
// [RL12] Clock enable rise leaves suspend unconditionally
// [RL13] Falling clock enable with idle command: power down
// [RL14] Power down during burst becomes suspend
// [RL15] Power down exits on rise with idle command
// [RL16] Burst stop ends any running burst
// [RL17] Writes after activate carry no bit mask
// [RL18] Strobe encoding selects the command
// [RL19] Refresh with clock enable low: self refresh
// [RL20] Byte mask low enables, high masks byte
// [RL21] Precharge one bank or all banks
// [RL22] Read data after column-strobe latency, then per clock
// [RL23] Mask blanks read two clocks later, write same cycle
// [RL24] Controller keeps row-active time limits
module sdram_command_bank_activate #(
   parameter int unsigned DATA_W = 32,
   parameter int unsigned ADDR_W = 12,
   parameter int unsigned BANK_W = 2,
   parameter int unsigned COL_W = 8,
   parameter int unsigned ROW_W = 4
) (
   // Clock and reset
   input logic i_mclk,
   input logic i_nrst,
   // Avalon-MM register slave
   input logic [4:0] i_avs_address,
   input logic i_avs_read,
   input logic i_avs_write,
   input logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Memory command pins
   input logic i_clk_gate,
   input logic i_cs_n,
   input logic i_ras_n,
   input logic i_cas_n,
   input logic i_we_n,
   input logic [BANK_W-1:0] i_bank_select,
   input logic [ADDR_W-1:0] i_addr,
   input logic [DATA_W/8-1:0] i_byte_mask,
   // Data pins, split into in, out and per-byte enable
   input logic [DATA_W-1:0] i_data_io,
   output logic [DATA_W-1:0] o_data_io,
   output logic [DATA_W/8-1:0] o_data_io_oe
);

   localparam int unsigned BANKS = 1 << BANK_W;
   localparam int unsigned MASK_W = DATA_W / 8;
   localparam int unsigned IDX_W = BANK_W + ROW_W + COL_W;

   // Pin samples, all taken on the rising edge
   logic cs_n_ff, ras_n_ff, cas_n_ff, we_n_ff, cke_ff, clk_gate_prev_ff;
   logic [BANK_W-1:0] ba_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [MASK_W-1:0] mask_ff;
   logic [DATA_W-1:0] din_ff;

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         cs_n_ff <= 1'b1;
         ras_n_ff <= 1'b1;
         cas_n_ff <= 1'b1;
         we_n_ff <= 1'b1;
         cke_ff <= 1'b0;
         clk_gate_prev_ff <= 1'b0;
         ba_ff <= '0;
         addr_ff <= '0;
         mask_ff <= '1;
         din_ff <= '0;
      end else begin
         cs_n_ff <= i_cs_n; // [RL1]
         ras_n_ff <= i_ras_n;
         cas_n_ff <= i_cas_n;
         we_n_ff <= i_we_n;
         cke_ff <= i_clk_gate;
         clk_gate_prev_ff <= cke_ff; // [RL10]
         ba_ff <= i_bank_select;
         addr_ff <= i_addr;
         mask_ff <= i_byte_mask;
         din_ff <= i_data_io;
      end
   end

   sdram_cmd_if cmd_bus ();

   sdram_cmd_decode u_decode (
      .i_cs_n(cs_n_ff),
      .i_ras_n(ras_n_ff),
      .i_cas_n(cas_n_ff),
      .i_we_n(we_n_ff),
      .i_clk_gate_prev(clk_gate_prev_ff),
      .i_clk_gate(cke_ff),
      .cmd_port(cmd_bus.dec)
   );

   // Control state
   sdram_pkg::power_mode_t mode_ff, nxt_mode;
   logic [BANKS-1:0] bank_act_ff, nxt_bank_act;
   logic [ADDR_W-1:0] bank_row_ff [BANKS];
   logic [ADDR_W-1:0] nxt_bank_row [BANKS];
   logic burst_on_ff, nxt_burst_on, burst_rd_ff, nxt_burst_rd, burst_ap_ff, nxt_burst_ap;
   logic burst_full_ff, nxt_burst_full;
   logic [BANK_W-1:0] burst_bank_ff, nxt_burst_bank;
   logic [COL_W-1:0] burst_col_ff, nxt_burst_col;
   logic [COL_W:0] burst_left_ff, nxt_burst_left;
   logic [1:0] cfg_cas_ff, nxt_cfg_cas;
   logic [2:0] cfg_bl_ff, nxt_cfg_bl;
   logic err_ff, nxt_err;

   logic live, act_go, rw_go, rw_bad, pre_one, pre_all, stop, ap_close;
   logic acc_on, acc_rd, last, cur_full;
   logic [BANK_W-1:0] acc_bank;
   logic [COL_W-1:0] acc_col, wrap_m;
   logic [COL_W:0] cur_left, bl_len;
   logic [IDX_W-1:0] acc_idx;

   // Suspend, power down and self refresh all freeze the command path
   assign live = cmd_bus.live && (mode_ff == sdram_pkg::PM_NORMAL); // [RL10]
   assign act_go = live && (cmd_bus.cmd == sdram_pkg::CMD_ACTIVATE) && !bank_act_ff[ba_ff];
   assign rw_go = live && bank_act_ff[ba_ff] // [RL9]
      && (cmd_bus.cmd == sdram_pkg::CMD_WRITE || cmd_bus.cmd == sdram_pkg::CMD_READ);
   assign rw_bad = live && !bank_act_ff[ba_ff]
      && (cmd_bus.cmd == sdram_pkg::CMD_WRITE || cmd_bus.cmd == sdram_pkg::CMD_READ);
   assign pre_one = live && (cmd_bus.cmd == sdram_pkg::CMD_PRECHARGE)
      && !addr_ff[sdram_pkg::AUTOPRECHARGE_BIT]; // [RL21]
   assign pre_all = live && (cmd_bus.cmd == sdram_pkg::CMD_PRECHARGE)
      && addr_ff[sdram_pkg::AUTOPRECHARGE_BIT]; // [RL21]
   assign stop = (live && cmd_bus.cmd == sdram_pkg::CMD_BURST_STOP) // [RL16]
      || pre_all || (pre_one && ba_ff == burst_bank_ff);

   always_comb begin
      unique case (cfg_bl_ff)
         sdram_pkg::BL_1: bl_len = (COL_W+1)'(1);
         sdram_pkg::BL_2: bl_len = (COL_W+1)'(2);
         sdram_pkg::BL_4: bl_len = (COL_W+1)'(4);
         sdram_pkg::BL_8: bl_len = (COL_W+1)'(8);
         default: bl_len = '0;
      endcase
   end

   // Burst sequencing: a new legal access preempts the running burst
   assign acc_on = rw_go || (live && burst_on_ff && !stop);
   assign acc_rd = rw_go ? (cmd_bus.cmd == sdram_pkg::CMD_READ) : burst_rd_ff;
   assign acc_bank = rw_go ? ba_ff : burst_bank_ff;
   assign acc_col = rw_go ? addr_ff[COL_W-1:0] : burst_col_ff;
   assign cur_full = rw_go ? (bl_len == '0) : burst_full_ff;
   assign cur_left = rw_go ? bl_len : burst_left_ff;
   assign last = !cur_full && (cur_left == (COL_W+1)'(1));
   assign ap_close = acc_on && last && (rw_go ? addr_ff[sdram_pkg::AUTOPRECHARGE_BIT]
      : burst_ap_ff); // [RL8]
   // Mask from the programmed length, not the beats left, so the wrap block stays fixed
   assign wrap_m = cur_full ? '1 : (bl_len[COL_W-1:0] - COL_W'(1));
   assign acc_idx = {acc_bank, bank_row_ff[acc_bank][ROW_W-1:0], acc_col};

   always_comb begin
      nxt_burst_on = burst_on_ff;
      nxt_burst_rd = burst_rd_ff;
      nxt_burst_ap = burst_ap_ff;
      nxt_burst_full = burst_full_ff;
      nxt_burst_bank = burst_bank_ff;
      nxt_burst_col = burst_col_ff;
      nxt_burst_left = burst_left_ff;
      if (live && stop && !rw_go) begin
         nxt_burst_on = 1'b0; // [RL16]
      end
      if (acc_on) begin
         nxt_burst_on = !last;
         nxt_burst_rd = acc_rd;
         nxt_burst_bank = acc_bank;
         nxt_burst_full = cur_full;
         nxt_burst_left = cur_left - (COL_W+1)'(1);
         if (rw_go) begin
            nxt_burst_ap = addr_ff[sdram_pkg::AUTOPRECHARGE_BIT]; // [RL8]
         end
         // Linear wrap inside the aligned burst block
         nxt_burst_col = (acc_col & ~wrap_m) | ((acc_col + COL_W'(1)) & wrap_m);
      end
   end

   // Power modes, entered and left through clock enable
   always_comb begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         sdram_pkg::PM_NORMAL: begin
            if (cmd_bus.cke_fall) begin
               if (cmd_bus.cmd == sdram_pkg::CMD_REFRESH && bank_act_ff == '0) begin
                  nxt_mode = sdram_pkg::PM_SELF_REFRESH; // [RL19]
               end else if (cmd_bus.idle_cmd && !burst_on_ff) begin
                  nxt_mode = sdram_pkg::PM_POWER_DOWN; // [RL13]
               end else begin
                  nxt_mode = sdram_pkg::PM_SUSPEND; // [RL11] [RL14]
               end
            end
         end
         sdram_pkg::PM_SUSPEND: begin
            if (cke_ff) begin
               nxt_mode = sdram_pkg::PM_NORMAL; // [RL12]
            end
         end
         sdram_pkg::PM_POWER_DOWN, sdram_pkg::PM_SELF_REFRESH: begin
            if (cke_ff && cmd_bus.idle_cmd) begin
               nxt_mode = sdram_pkg::PM_NORMAL; // [RL15] [RL19]
            end
         end
      endcase
   end

   // Per-bank open state and latched row
   genvar gb;
   generate
      for (gb = 0; gb < BANKS; gb++) begin : g_bank
         always_comb begin
            nxt_bank_act[gb] = bank_act_ff[gb];
            nxt_bank_row[gb] = bank_row_ff[gb];
            if (act_go && ba_ff == BANK_W'(gb)) begin
               nxt_bank_act[gb] = 1'b1; // [RL2]
               nxt_bank_row[gb] = addr_ff; // [RL3]
            end
            if (pre_all || (pre_one && ba_ff == BANK_W'(gb))) begin
               nxt_bank_act[gb] = 1'b0; // [RL21]
            end
            if (ap_close && acc_bank == BANK_W'(gb)) begin
               nxt_bank_act[gb] = 1'b0; // [RL8]
            end
         end
         always_ff @(posedge i_mclk or negedge i_nrst) begin
            if (!i_nrst) begin
               bank_act_ff[gb] <= 1'b0;
               bank_row_ff[gb] <= '0;
            end else begin
               bank_act_ff[gb] <= nxt_bank_act[gb];
               bank_row_ff[gb] <= nxt_bank_row[gb];
            end
         end
      end
   endgenerate

   // Storage keeps ROW_W low row bits only, to stay simulation-sized
   logic [DATA_W-1:0] rd_word, pipe_data_ff, nxt_pipe_data, dout_ff, nxt_dout;
   logic pipe_vld_ff, nxt_pipe_vld, sel_vld;
   logic [MASK_W-1:0] oe_ff, nxt_oe;

   genvar gy;
   generate
      for (gy = 0; gy < MASK_W; gy++) begin : g_byte
         // One array per byte lane, so each array has a single writer
         logic [7:0] mem [1 << IDX_W];
         assign rd_word[gy*8 +: 8] = mem[acc_idx];
         // Write data lands only on unmasked bytes, no per-bit mask
         always_ff @(posedge i_mclk) begin
            if (acc_on && !acc_rd && !mask_ff[gy]) begin
               mem[acc_idx] <= din_ff[gy*8 +: 8]; // [RL17] [RL20] [RL23]
            end
         end
      end
   endgenerate

   // Latency two drives straight from the array, three via one stage
   assign sel_vld = (cfg_cas_ff == sdram_pkg::CAS_TWO) ? (acc_on && acc_rd) : pipe_vld_ff;

   always_comb begin
      nxt_pipe_data = pipe_data_ff;
      nxt_pipe_vld = pipe_vld_ff;
      nxt_dout = dout_ff;
      nxt_oe = oe_ff;
      if (cmd_bus.live) begin
         nxt_pipe_data = rd_word;
         nxt_pipe_vld = acc_on && acc_rd;
         nxt_dout = (cfg_cas_ff == sdram_pkg::CAS_TWO) ? rd_word : pipe_data_ff; // [RL22]
         // Mask sampled one edge before this load covers the beat two clocks on
         nxt_oe = {MASK_W{sel_vld}} & ~mask_ff; // [RL20] [RL23]
      end
   end

   // Avalon slave: one wait cycle, then a one-cycle answer
   logic wait_ff, nxt_wait;
   logic [31:0] rdata_ff, nxt_rdata;
   logic wr_go;

   assign wr_go = i_avs_write && !wait_ff;
   assign nxt_wait = !((i_avs_read || i_avs_write) && wait_ff);

   always_comb begin
      nxt_rdata = rdata_ff;
      if ((i_avs_read || i_avs_write) && wait_ff) begin
         nxt_rdata = '0;
         if (i_avs_address == sdram_pkg::REG_CONFIG) begin
            nxt_rdata[sdram_pkg::CFG_CAS_LSB +: 2] = cfg_cas_ff;
            nxt_rdata[sdram_pkg::CFG_BL_LSB +: 3] = cfg_bl_ff;
         end else if (i_avs_address == sdram_pkg::REG_STATUS) begin
            nxt_rdata[BANKS-1:0] = bank_act_ff;
            nxt_rdata[sdram_pkg::ST_MODE_LSB +: 2] = mode_ff;
            nxt_rdata[sdram_pkg::ST_BURST_BIT] = burst_on_ff;
         end else if (i_avs_address == sdram_pkg::REG_ERROR) begin
            nxt_rdata[sdram_pkg::ERR_ILLEGAL_BIT] = err_ff;
         end else if (i_avs_address >= sdram_pkg::REG_ROW0 && i_avs_address[1:0] == 2'h0) begin
            nxt_rdata[ADDR_W-1:0] = bank_row_ff[i_avs_address[BANK_W+1:2]];
         end
      end
   end

   always_comb begin
      nxt_cfg_cas = cfg_cas_ff;
      nxt_cfg_bl = cfg_bl_ff;
      nxt_err = err_ff;
      if (wr_go && i_avs_address == sdram_pkg::REG_CONFIG) begin
         nxt_cfg_cas = i_avs_writedata[sdram_pkg::CFG_CAS_LSB +: 2];
         nxt_cfg_bl = i_avs_writedata[sdram_pkg::CFG_BL_LSB +: 3];
      end
      if (wr_go && i_avs_address == sdram_pkg::REG_ERROR
          && i_avs_writedata[sdram_pkg::ERR_ILLEGAL_BIT]) begin
         nxt_err = 1'b0;
      end
      // Set after clear so a coinciding event is kept
      if (rw_bad || (live && cmd_bus.cmd == sdram_pkg::CMD_ACTIVATE && bank_act_ff[ba_ff])) begin
         nxt_err = 1'b1; // [RL9]
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         mode_ff <= sdram_pkg::PM_NORMAL;
         burst_on_ff <= 1'b0;
         burst_rd_ff <= 1'b0;
         burst_ap_ff <= 1'b0;
         burst_full_ff <= 1'b0;
         burst_bank_ff <= '0;
         burst_col_ff <= '0;
         burst_left_ff <= '0;
         pipe_data_ff <= '0;
         pipe_vld_ff <= 1'b0;
         dout_ff <= '0;
         oe_ff <= '0;
         wait_ff <= sdram_pkg::WAIT_RESET;
         rdata_ff <= '0;
         cfg_cas_ff <= sdram_pkg::CAS_RESET;
         cfg_bl_ff <= sdram_pkg::BL_RESET;
         err_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         burst_on_ff <= nxt_burst_on;
         burst_rd_ff <= nxt_burst_rd;
         burst_ap_ff <= nxt_burst_ap;
         burst_full_ff <= nxt_burst_full;
         burst_bank_ff <= nxt_burst_bank;
         burst_col_ff <= nxt_burst_col;
         burst_left_ff <= nxt_burst_left;
         pipe_data_ff <= nxt_pipe_data;
         pipe_vld_ff <= nxt_pipe_vld;
         dout_ff <= nxt_dout;
         oe_ff <= nxt_oe;
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
         cfg_cas_ff <= nxt_cfg_cas;
         cfg_bl_ff <= nxt_cfg_bl;
         err_ff <= nxt_err;
      end
   end

   assign o_avs_waitrequest = wait_ff;
   assign o_avs_readdata = rdata_ff;
   assign o_data_io = dout_ff;
   assign o_data_io_oe = oe_ff;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   sequence s_rd_go;
      rw_go && cmd_bus.cmd == sdram_pkg::CMD_READ && cfg_cas_ff == sdram_pkg::CAS_TWO;
   endsequence
   sequence s_first_beat;
      o_data_io_oe == '1;
   endsequence

   a_activate_opens: assert property (act_go |=> bank_act_ff[$past(ba_ff)]) // [RL2]
      else $error("activate did not open bank");
   a_row_latched: assert property (act_go |=> bank_row_ff[$past(ba_ff)] == $past(addr_ff)) // [RL3]
      else $error("row address not latched");
   a_prech_every: assert property (pre_all |=> bank_act_ff == '0) // [RL21]
      else $error("precharge of every bank left one open");
   a_idle_access_flag: assert property (rw_bad |=> err_ff && $stable(burst_bank_ff)) // [RL9]
      else $error("access to idle bank not flagged");
   a_frozen_commands: assert property (!clk_gate_prev_ff |=> $stable(bank_act_ff)) // [RL10]
      else $error("bank state moved with clock enable low");
   a_burst_suspend: assert property (mode_ff == sdram_pkg::PM_NORMAL && cmd_bus.cke_fall
      && burst_on_ff |=> mode_ff == sdram_pkg::PM_SUSPEND) // [RL14]
      else $error("burst did not turn power down into suspend");
   a_power_down_in: assert property (mode_ff == sdram_pkg::PM_NORMAL && cmd_bus.cke_fall
      && cmd_bus.idle_cmd && !burst_on_ff |=> mode_ff == sdram_pkg::PM_POWER_DOWN) // [RL13]
      else $error("power down not entered");
   a_suspend_out: assert property (mode_ff == sdram_pkg::PM_SUSPEND && cke_ff
      |=> mode_ff == sdram_pkg::PM_NORMAL) // [RL12]
      else $error("suspend not left");
   a_power_down_out: assert property (mode_ff == sdram_pkg::PM_POWER_DOWN && cke_ff
      && !cmd_bus.idle_cmd |=> mode_ff == sdram_pkg::PM_POWER_DOWN) // [RL15]
      else $error("power down left without idle command");
   a_burst_stop: assert property (live && cmd_bus.cmd == sdram_pkg::CMD_BURST_STOP
      |=> !burst_on_ff) // [RL16]
      else $error("burst stop ignored");
   a_auto_close: assert property (ap_close |=> !bank_act_ff[$past(acc_bank)]) // [RL8]
      else $error("auto precharge left bank open");
   a_read_latency: assert property (s_rd_go ##0 mask_ff == '0 |=> s_first_beat) // [RL22]
      else $error("read data late for latency two");

endmodule : sdram_command_bank_activate

// *** mem_ctrl_model.sv ***
// Memory controller model driving the command pins of the DRAM block
`timescale 1ns/100ps
module mem_ctrl_model #(
   parameter int unsigned ACT_GAP = 3
) (
   // Clock
   input wire logic i_mclk,
   // Command and data pins toward the memory
   output logic o_clk_gate,
   output logic [3:0] o_strobe_n,
   output logic [1:0] o_bank_select,
   output logic [11:0] o_addr,
   output logic [3:0] o_byte_mask,
   output logic [31:0] o_data_io
);
   initial begin
      o_clk_gate = 1'b1;
      o_strobe_n = 4'hF;
      o_bank_select = 2'h0;
      o_addr = 12'h000;
      o_byte_mask = 4'h0;
      o_data_io = 32'h00000000;
   end

   // One command cycle then a no-operation; released data shows its inverse
   task automatic issue(input logic [3:0] s, input logic [1:0] b, input logic [11:0] a,
      input logic [3:0] m, input logic [31:0] d, input logic ce);
      @(posedge i_mclk);
      o_strobe_n <= s;
      o_bank_select <= b;
      o_addr <= a;
      o_byte_mask <= m;
      o_data_io <= d;
      o_clk_gate <= ce;
      @(posedge i_mclk);
      o_strobe_n <= 4'h7;
      o_data_io <= ~d;
      // Fixed gap after activate stands in for every minimum spacing
      if (s == 4'h3) repeat (ACT_GAP) @(posedge i_mclk);
   endtask : issue
endmodule : mem_ctrl_model

// *** testbench.sv ***
// Self-checking bench for the DRAM command and bank block
`timescale 1ns/100ps
module testbench;
   localparam logic [3:0] ACT = 4'h3;
   localparam logic [3:0] PRE = 4'h2;
   localparam logic [3:0] WRC = 4'h4;
   localparam logic [3:0] RDC = 4'h5;
   localparam logic [3:0] REF = 4'h1;
   localparam logic [3:0] NOP = 4'h7;
   localparam logic [3:0] BST = 4'h6;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic clk_gate;
   logic [3:0] strobe_n;
   logic [1:0] bank_select;
   logic [11:0] addr;
   logic [3:0] byte_mask;
   logic [31:0] data_in;
   logic [31:0] data_out;
   logic [3:0] data_oe;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #50 i_mclk = ~i_mclk;

   mem_ctrl_model mem_ctrl_model_i (.i_mclk(i_mclk), .o_clk_gate(clk_gate),
      .o_strobe_n(strobe_n), .o_bank_select(bank_select), .o_addr(addr),
      .o_byte_mask(byte_mask), .o_data_io(data_in));

   sdram_command_bank_activate sdram_command_bank_activate_i (.i_mclk(i_mclk),
      .i_nrst(i_nrst), .i_avs_address(avs_address), .i_avs_read(avs_read),
      .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
      .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
      .i_clk_gate(clk_gate), .i_cs_n(strobe_n[3]), .i_ras_n(strobe_n[2]),
      .i_cas_n(strobe_n[1]), .i_we_n(strobe_n[0]), .i_bank_select(bank_select),
      .i_addr(addr), .i_byte_mask(byte_mask), .i_data_io(data_in),
      .o_data_io(data_out), .o_data_io_oe(data_oe));

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   always @(posedge i_mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         summarize();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge i_mclk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= ~w;
      avs_write <= w;
      do begin
         @(posedge i_mclk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rchk(input string n, input logic [4:0] a, input logic [31:0] m,
      input logic [31:0] e);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk(n, e, rd & m);
   endtask : rchk

   task automatic wreg(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask : wreg

   task automatic cmd(input logic [3:0] s, input logic [1:0] b, input logic [11:0] a,
      input logic [3:0] m, input logic [31:0] d, input logic ce);
      mem_ctrl_model_i.issue(s, b, a, m, d, ce);
      repeat (3) @(posedge i_mclk);
   endtask : cmd

   // Single-beat read: waits for the drive enable, then checks the beat and its end
   task automatic beat(input logic [31:0] e, input logic [31:0] dm, input logic [3:0] eo);
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (data_oe === 4'h0 && n < 8);
      chk("oe", {28'h0, eo}, {28'h0, data_oe});
      chk("data", e & dm, data_out & dm);
      @(posedge i_mclk);
      chk("oe end", 32'h0, {28'h0, data_oe});
   endtask : beat

   task automatic t_regs();
      rchk("config", 5'h00, 32'h1F, 32'h0E);
      rchk("unmapped", 5'h0C, 32'hFFFFFFFF, 32'h0);
      wreg(5'h00, 32'h02);
      rchk("config", 5'h00, 32'h1F, 32'h02);
   endtask : t_regs

   task automatic t_activate();
      cmd(ACT, 2'h1, 12'h5A5, 4'h0, 32'h0, 1'b1);
      cmd(ACT, 2'h2, 12'h0C3, 4'h0, 32'h0, 1'b1);
      rchk("status", 5'h04, 32'h0F, 32'h6);
      rchk("row1", 5'h14, 32'hFFF, 32'h5A5);
      rchk("row2", 5'h18, 32'hFFF, 32'h0C3);
   endtask : t_activate

   task automatic t_illegal();
      cmd(RDC, 2'h0, 12'h000, 4'h0, 32'h0, 1'b1);
      rchk("error", 5'h08, 32'h1, 32'h1);
      wreg(5'h08, 32'h1);
      rchk("error", 5'h08, 32'h1, 32'h0);
   endtask : t_illegal

   task automatic t_data();
      cmd(WRC, 2'h1, 12'h003, 4'h0, 32'hA1B2C3D4, 1'b1);
      cmd(WRC, 2'h1, 12'h003, 4'hF, 32'hFFFFFFFF, 1'b1);
      mem_ctrl_model_i.issue(RDC, 2'h1, 12'h003, 4'h0, 32'h0, 1'b1);
      beat(32'hA1B2C3D4, 32'hFFFFFFFF, 4'hF);
      mem_ctrl_model_i.issue(RDC, 2'h1, 12'h003, 4'h1, 32'h0, 1'b1);
      beat(32'hA1B2C3D4, 32'hFFFFFF00, 4'hE);
   endtask : t_data

   task automatic t_close();
      cmd(RDC, 2'h2, 12'h400, 4'h0, 32'h0, 1'b1);
      rchk("status", 5'h04, 32'h0F, 32'h2);
      cmd(ACT, 2'h2, 12'h0C3, 4'h0, 32'h0, 1'b1);
      cmd(PRE, 2'h2, 12'h000, 4'h0, 32'h0, 1'b1);
      rchk("status", 5'h04, 32'h0F, 32'h2);
      cmd(PRE, 2'h0, 12'h400, 4'h0, 32'h0, 1'b1);
      rchk("status", 5'h04, 32'h0F, 32'h0);
   endtask : t_close

   task automatic t_power();
      cmd(NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
      rchk("mode", 5'h04, 32'h30, 32'h20);
      cmd(ACT, 2'h3, 12'h001, 4'h0, 32'h0, 1'b0);
      rchk("status", 5'h04, 32'h3F, 32'h20);
      cmd(NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b1);
      rchk("mode", 5'h04, 32'h30, 32'h00);
      cmd(REF, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
      rchk("mode", 5'h04, 32'h30, 32'h30);
      cmd(NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b1);
      rchk("mode", 5'h04, 32'h30, 32'h00);
   endtask : t_power

   // Full-page burst so that only the stop can end it
   task automatic t_suspend();
      wreg(5'h00, 32'h1E);
      cmd(ACT, 2'h0, 12'h010, 4'h0, 32'h0, 1'b1);
      mem_ctrl_model_i.issue(RDC, 2'h0, 12'h000, 4'h0, 32'h0, 1'b1);
      mem_ctrl_model_i.issue(NOP, 2'h0, 12'h000, 4'h0, 32'h0, 1'b0);
      rchk("suspend", 5'h04, 32'h70, 32'h50);
      mem_ctrl_model_i.issue(RDC, 2'h0, 12'h000, 4'h0, 32'h0, 1'b1);
      mem_ctrl_model_i.issue(BST, 2'h0, 12'h000, 4'h0, 32'h0, 1'b1);
      rchk("resume", 5'h04, 32'h70, 32'h00);
   endtask : t_suspend

   initial begin
      repeat (12) @(posedge i_mclk);
      i_nrst <= 1'b1;
      t_regs();
      t_activate();
      t_illegal();
      t_data();
      t_close();
      t_power();
      t_suspend();
      summarize();
   end
endmodule : testbench
